//--- pkg/rx_cfg.svh
// Purpose: constants of the serial receiver with error and wakeup logic
// Assumes: 250 MHz clock, registers as 32-bit words on AXI4-Lite
// Notes: sample position sixteen of a bit is held as zero
// Summary of operation
// - No logic 1 in the stop bit position sets the framing error flag.
// - Framing error sets in the same cycle as receive-full.
// - A break character, lacking a stop bit, also sets framing error.
// - Stop bit judged from three samples: one off is noise, more is framing error.
// - Resynchronise the sample counter on valid falling edges inside a character.
// - Stop sampling ends 16 ticks per preceding bit plus 10: 154 or 170.
// - Setting standby control suppresses all receiver interrupt requests while it lasts.
// - Address-mark wakeup: character with msb 1 clears standby and sets receive-full.
// - Idle wakeup: idle character clears standby without setting idle or receive-full.
// - Idle type selects counting ones after start bit or after stop bit.
// - Switching to idle wakeup on an already idle line may wake at once.
// - Character moved to buffer sets receive-full; interrupt only when enabled.
// - Idle flag sets after 10 or 11 ones; interrupt only when enabled.
// - Overrun keeps old buffer, drops new character, sets overrun flag; enable gates.
// - Noise in start, data or stop bits sets noise flag; enable gates.
// - Failed parity check sets parity error flag; enable gates interrupt.
// - Framing error requests an error interrupt only when its enable is set.
// - In wait mode the block keeps running and enabled requests still assert.
// - In wait mode registers are not accessible to the processor.
// - Stop mode halts the block, keeps registers; transfer in progress is invalid.
// - Break with clear-enable low: accesses leave flags; begun clears finish after.
// - Break with clear-enable high: flags may be cleared and stay cleared.
// - Sample clock runs at sixteen times baud; line sampled every tick.
// - Bit value is majority of samples eight to ten; disagreement flags noise.
`ifndef RX_CFG_SVH
`define RX_CFG_SVH
`define OFS_CONTROL_ONE      8'h00
`define OFS_CONTROL_TWO      8'h04
`define OFS_CONTROL_THREE    8'h08
`define OFS_STATUS_ONE       8'h0c
`define OFS_DATA             8'h10
`define OFS_BAUD             8'h14
`define CHAR_NINE            0
`define WAKE_ON_MARK         1
`define IDLE_COUNT_START_SEL 2
`define PARITY_EN            3
`define PARITY_ODD           4
`define RX_MODULE_EN         5
`define RX_FULL_IRQ_EN       0
`define LINE_IDLE_IRQ_EN     1
`define RX_STANDBY_CTL       2
`define RX_EN                3
`define R8_BIT               8
`define FLAG_FULL            0
`define FLAG_IDLE            1
`define FLAG_OVERRUN         2
`define FLAG_NOISE           3
`define FLAG_FRAMING         4
`define FLAG_PARITY          5
`define PH_FIRST             4'h1
`define PH_START_A           4'h3
`define PH_START_B           4'h5
`define PH_VERIFY            4'h7
`define PH_DECIDE            4'ha
`define PH_BIT_END           4'h0
`define PH_LATE              4'hb
`define LAST_BIT_EIGHT       4'h7
`define LAST_BIT_NINE        4'h8
`define IDLE_BITS_EIGHT      4'ha
`define IDLE_BITS_NINE       4'hb
`define ONES_MAX             4'hf
`define BAUD_RESET           16'h00ff
`define LINE_IDLE            1'b1
`define HIST_IDLE            3'h7
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

//--- pkg/rx_pkg.sv
// Purpose: types of the serial receiver
// Assumes: constants live in rx_cfg.svh
// Notes: frame states are one-hot
package rx_pkg;
  typedef enum logic [3:0] {
    IDLE_S  = 4'b0001,
    START_S = 4'b0010,
    DATA_S  = 4'b0100,
    STOP_S  = 4'b1000
  } rx_state_type;
endpackage

//--- pkg/sample_if.sv
// Purpose: sample clock and synchronised line between receiver and sampler
// Assumes: one clock domain
// Notes: pinLevel is the raw asynchronous pin
`timescale 1ns/1ps
interface sample_if;
  logic        run;
  logic [15:0] divisor;
  logic        pinLevel;
  logic        tick;
  logic        lineLevel;
  modport source (input run, input divisor, input pinLevel, output tick, output lineLevel);
  modport sink   (output run, output divisor, output pinLevel, input tick, input lineLevel);
endinterface

//--- core/rx_sample_clock.sv
// Purpose: sixteen-times-baud tick and synchronised receive line
// Assumes: divisor set so that one tick every divisor+1 clocks is 16x baud
// Notes: tick is a one-cycle enable, never a clock
`timescale 1ns/1ps
`include "rx_cfg.svh"
module rx_sample_clock (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // sample clock and line
  sample_if.source  smp
);
  logic [15:0] divCount_reg;
  logic [1:0]  pinSync_reg;
  logic        tick_reg;
  logic        line_reg;

  assign smp.tick      = tick_reg;
  assign smp.lineLevel = line_reg;

  // halting the divider in stop mode freezes the whole receiver
  always_ff @(posedge clock) begin
    if (rst || !smp.run) begin
      divCount_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (divCount_reg >= smp.divisor) begin
      divCount_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      divCount_reg <= divCount_reg + 16'h0001;
      tick_reg     <= 1'b0;
    end
  end

  // the first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      pinSync_reg <= {2{`LINE_IDLE}};
      line_reg    <= `LINE_IDLE;
    end else begin
      pinSync_reg <= {pinSync_reg[0], smp.pinLevel};
      line_reg    <= pinSync_reg[1];
    end
  end
endmodule

//--- core/sci_receiver_error_wakeup.sv
// Purpose: receiver framing, noise, parity, overrun, idle and wakeup logic
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: status flags clear by reading status then reading data
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rx_cfg.svh"
module sci_receiver_error_wakeup
  import rx_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // receive pin
  input  wire logic        rxPin,
  // processor mode and debug break
  input  wire logic        waitMode,
  input  wire logic        stopMode,
  input  wire logic        breakState,
  input  wire logic        breakClearEn,
  // write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  // read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // interrupt requests
  output logic             rxIrq,
  output logic             errIrq
);
  logic [5:0]   control_one_reg;
  logic [3:0]   control_two_reg;
  logic [3:0]   control_three_reg;
  logic [5:0]   status_one_reg;
  logic [5:0]   armed_reg;
  logic [7:0]   rx_data_buffer;
  logic         r8_reg;
  logic [15:0]  baud_reg;
  rx_state_type state_reg;
  logic [3:0]   phase_reg;
  logic [3:0]   bitIdx_reg;
  logic [2:0]   hist_reg;
  logic [1:0]   startSmp_reg;
  logic [8:0]   shift_reg;
  logic         lastBit_reg;
  logic         noiseAcc_reg;
  logic [3:0]   oneBits_reg;
  logic         idleArmed_reg;
  logic         awHeld_reg;
  logic         wHeld_reg;
  logic [7:0]   awAddr_reg;
  logic [31:0]  wData_reg;
  logic [3:0]   wStrb_reg;

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic noisy3(input logic [2:0] s);
    return (|s) & ~(&s);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == `OFS_CONTROL_ONE) || (a == `OFS_CONTROL_TWO) || (a == `OFS_CONTROL_THREE) ||
           (a == `OFS_STATUS_ONE) || (a == `OFS_DATA) || (a == `OFS_BAUD);
  endfunction

  logic       rxRun;
  logic       rxOn;
  logic       standby;
  logic       char9;
  logic       tickRun;
  logic [2:0] cur3;
  logic       vote;
  logic [3:0] phaseNow;
  logic       fall;
  logic       resync;
  logic       resyncLate;
  logic       startEnter;
  logic       dataDecide;
  logic       stopDecide;
  logic       idleDecide;
  logic       bitEnd;
  logic [8:0] recv;
  logic       msb;
  logic       wakeByMark;
  logic       acceptChar;
  logic       overrunEv;
  logic       loadEv;
  logic [3:0] idleLen;
  logic       idleHit;
  logic       idleEv;
  logic       wakeIdle;
  logic       protect;
  logic       statusRead;
  logic       dataRead;
  logic       writeGo;
  logic       wrOk;
  logic [5:0] setVec;
  logic [5:0] clrVec;
  logic [3:0] onesInc;
  logic [31:0] readWord;

  sample_if smp();

  rx_sample_clock u_sampler (
    .clock (clock),
    .rst   (rst),
    .smp   (smp)
  );

  assign rxRun        = control_one_reg[`RX_MODULE_EN] & control_two_reg[`RX_EN];
  assign rxOn         = rxRun & ~stopMode;
  assign smp.run      = rxOn;
  assign smp.divisor  = baud_reg;
  assign smp.pinLevel = rxPin;
  assign standby      = control_two_reg[`RX_STANDBY_CTL];
  assign char9        = control_one_reg[`CHAR_NINE];
  assign tickRun      = smp.tick & rxOn;
  assign cur3         = {hist_reg[1:0], smp.lineLevel};
  assign vote         = maj3(cur3);
  assign phaseNow     = phase_reg + 4'h1;
  assign fall         = hist_reg[0] & ~smp.lineLevel;

  // resync only after a decided 1, outside the majority sampling window
  assign resyncLate = (phaseNow >= `PH_LATE) || (phaseNow == `PH_BIT_END);
  assign resync     = tickRun & fall & lastBit_reg & (state_reg == DATA_S || state_reg == STOP_S) &
                      (resyncLate || (phaseNow > `PH_FIRST && phaseNow <= `PH_VERIFY));
  assign startEnter = tickRun && state_reg == IDLE_S && fall && hist_reg == `HIST_IDLE;
  assign dataDecide = tickRun && state_reg == DATA_S && phaseNow == `PH_DECIDE;
  assign stopDecide = tickRun && state_reg == STOP_S && phaseNow == `PH_DECIDE;
  assign idleDecide = tickRun && state_reg == IDLE_S && phaseNow == `PH_DECIDE;
  assign bitEnd     = tickRun && state_reg == DATA_S && (phaseNow == `PH_BIT_END || (resync && resyncLate));

  assign recv = char9 ? shift_reg : {1'b0, shift_reg[8:1]};
  assign msb  = char9 ? recv[8] : recv[7];

  // a discarded character in standby touches no flag
  assign wakeByMark = stopDecide & standby & control_one_reg[`WAKE_ON_MARK] & msb;
  assign acceptChar = stopDecide & (~standby | wakeByMark);
  assign overrunEv  = acceptChar & status_one_reg[`FLAG_FULL] & ~clrVec[`FLAG_FULL];
  assign loadEv     = acceptChar & ~overrunEv;

  assign idleLen  = char9 ? `IDLE_BITS_NINE : `IDLE_BITS_EIGHT;
  assign idleHit  = oneBits_reg >= idleLen;
  assign idleEv   = rxRun & idleHit & idleArmed_reg & ~standby;
  // no fresh idle needed, so an already idle line wakes at once
  assign wakeIdle = rxRun & standby & ~control_one_reg[`WAKE_ON_MARK] & idleHit;
  assign onesInc  = (oneBits_reg == `ONES_MAX) ? oneBits_reg : oneBits_reg + 4'h1;

  assign protect    = breakState & ~breakClearEn;
  assign statusRead = arvalid & arready & ~waitMode & (araddr == `OFS_STATUS_ONE) & ~protect;
  assign dataRead   = arvalid & arready & ~waitMode & (araddr == `OFS_DATA) & ~protect;
  assign writeGo    = awHeld_reg & wHeld_reg & ~bvalid;
  assign wrOk       = writeGo & ~waitMode & mapped(awAddr_reg);

  always_comb begin
    setVec                = '0;
    setVec[`FLAG_FULL]    = loadEv;
    setVec[`FLAG_IDLE]    = idleEv;
    setVec[`FLAG_OVERRUN] = overrunEv;
    setVec[`FLAG_NOISE]   = acceptChar & (noiseAcc_reg | noisy3(cur3));
    // a break arrives with no stop bit and lands here too
    setVec[`FLAG_FRAMING] = loadEv & ~vote;
    setVec[`FLAG_PARITY]  = loadEv & control_one_reg[`PARITY_EN] &
                            ((^recv) ^ control_one_reg[`PARITY_ODD]);
    clrVec                = dataRead ? armed_reg : '0;
  end

  always_comb begin
    readWord = '0;
    unique case (araddr)
      `OFS_CONTROL_ONE:   readWord[5:0] = control_one_reg;
      `OFS_CONTROL_TWO:   readWord[3:0] = control_two_reg;
      `OFS_CONTROL_THREE: readWord      = {23'h0, r8_reg, 4'h0, control_three_reg};
      `OFS_STATUS_ONE:    readWord[5:0] = status_one_reg;
      `OFS_DATA:          readWord[7:0] = rx_data_buffer;
      `OFS_BAUD:          readWord[15:0] = baud_reg;
      default:            readWord      = '0;
    endcase
  end

  // frame sequencer; stop mode just freezes it between ticks
  always_ff @(posedge clock) begin
    if (rst || !rxRun) begin
      state_reg  <= IDLE_S;
      phase_reg  <= `PH_BIT_END;
      bitIdx_reg <= '0;
    end else if (tickRun) begin
      phase_reg <= phaseNow;
      unique case (state_reg)
        IDLE_S: begin
          if (startEnter) begin
            state_reg <= START_S;
            phase_reg <= `PH_FIRST;
          end
        end
        START_S: begin
          if (phaseNow == `PH_VERIFY && maj3({startSmp_reg, smp.lineLevel})) begin
            state_reg <= IDLE_S;
          end else if (phaseNow == `PH_BIT_END) begin
            state_reg  <= DATA_S;
            bitIdx_reg <= '0;
          end
        end
        DATA_S: begin
          if (resync) begin
            phase_reg <= `PH_FIRST;
          end
          if (bitEnd) begin
            if (bitIdx_reg == (char9 ? `LAST_BIT_NINE : `LAST_BIT_EIGHT)) begin
              state_reg <= STOP_S;
            end else begin
              bitIdx_reg <= bitIdx_reg + 4'h1;
            end
          end
        end
        STOP_S: begin
          if (phaseNow == `PH_DECIDE) begin
            state_reg <= IDLE_S;
          end else if (resync) begin
            phase_reg <= `PH_FIRST;
          end
        end
      endcase
    end
  end

  // sample history, shift register and noise collection
  always_ff @(posedge clock) begin
    if (rst) begin
      hist_reg     <= `HIST_IDLE;
      startSmp_reg <= '0;
      shift_reg    <= '0;
      lastBit_reg  <= 1'b0;
      noiseAcc_reg <= 1'b0;
    end else if (tickRun) begin
      hist_reg <= cur3;
      if (startEnter) begin
        lastBit_reg  <= 1'b0;
        noiseAcc_reg <= 1'b0;
      end
      if (state_reg == START_S) begin
        if (phaseNow == `PH_START_A || phaseNow == `PH_START_B) begin
          startSmp_reg <= {startSmp_reg[0], smp.lineLevel};
        end
        if (phaseNow == `PH_VERIFY && (|{startSmp_reg, smp.lineLevel})) begin
          noiseAcc_reg <= 1'b1;
        end
        if (phaseNow == `PH_DECIDE && (|cur3)) begin
          noiseAcc_reg <= 1'b1;
        end
      end
      if (dataDecide) begin
        shift_reg   <= {vote, shift_reg[8:1]};
        lastBit_reg <= vote;
        if (noisy3(cur3)) begin
          noiseAcc_reg <= 1'b1;
        end
      end
      if (stopDecide) begin
        lastBit_reg <= vote;
      end
    end
  end

  // consecutive ones per bit time feed idle detection
  always_ff @(posedge clock) begin
    if (rst || !rxRun) begin
      oneBits_reg   <= '0;
      idleArmed_reg <= 1'b0;
    end else begin
      if (startEnter) begin
        oneBits_reg   <= '0;
        idleArmed_reg <= 1'b1;
      end else if (dataDecide || stopDecide) begin
        oneBits_reg <= (vote && !control_one_reg[`IDLE_COUNT_START_SEL]) ? onesInc : '0;
      end else if (idleDecide) begin
        oneBits_reg <= vote ? onesInc : '0;
      end
      if (idleHit) begin
        idleArmed_reg <= 1'b0;
      end
    end
  end

  // hardware set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status_one_reg <= '0;
      armed_reg      <= '0;
    end else begin
      status_one_reg <= (status_one_reg & ~clrVec) | setVec;
      if (statusRead) begin
        armed_reg <= status_one_reg;
      end else if (dataRead) begin
        armed_reg <= '0;
      end
    end
  end

  // on overrun the old character stays put
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_data_buffer <= '0;
      r8_reg         <= 1'b0;
    end else if (loadEv) begin
      rx_data_buffer <= recv[7:0];
      r8_reg         <= msb;
    end
  end

  // control registers; a wakeup overrides a software write in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      control_one_reg   <= '0;
      control_two_reg   <= '0;
      control_three_reg <= '0;
      baud_reg          <= `BAUD_RESET;
    end else begin
      if (wrOk && wStrb_reg[0]) begin
        unique case (awAddr_reg)
          `OFS_CONTROL_ONE:   control_one_reg   <= wData_reg[5:0];
          `OFS_CONTROL_TWO:   control_two_reg   <= wData_reg[3:0];
          `OFS_CONTROL_THREE: control_three_reg <= wData_reg[3:0];
          `OFS_BAUD:          baud_reg[7:0]     <= wData_reg[7:0];
          default:            ;
        endcase
      end
      if (wrOk && wStrb_reg[1] && awAddr_reg == `OFS_BAUD) begin
        baud_reg[15:8] <= wData_reg[15:8];
      end
      if (wakeByMark || wakeIdle) begin
        control_two_reg[`RX_STANDBY_CTL] <= 1'b0;
      end
    end
  end

  // requests keep running in wait mode so they can wake the processor
  always_ff @(posedge clock) begin
    if (rst) begin
      rxIrq  <= 1'b0;
      errIrq <= 1'b0;
    end else begin
      rxIrq  <= ~standby & ((status_one_reg[`FLAG_FULL] & control_two_reg[`RX_FULL_IRQ_EN]) |
                            (status_one_reg[`FLAG_IDLE] & control_two_reg[`LINE_IDLE_IRQ_EN]));
      errIrq <= ~standby & (|(status_one_reg[`FLAG_PARITY:`FLAG_OVERRUN] & control_three_reg));
    end
  end

  // write channels are taken in either order, answered once both are held
  always_ff @(posedge clock) begin
    if (rst) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wStrb_reg  <= '0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wready    <= 1'b0;
      end
      if (writeGo) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      if (waitMode || !mapped(araddr)) begin
        rdata <= '0;
        rresp <= `RESP_SLVERR;
      end else begin
        rdata <= readWord;
        rresp <= `RESP_OKAY;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  a_framing_on_load: assert property (@(posedge clock) disable iff (rst)
    (loadEv && !vote) |=> status_one_reg[`FLAG_FRAMING])
    else $error("framing error not set for missing stop bit");
  a_framing_with_full: assert property (@(posedge clock) disable iff (rst)
    $rose(status_one_reg[`FLAG_FRAMING]) |-> status_one_reg[`FLAG_FULL] && $past(setVec[`FLAG_FULL]))
    else $error("framing error rose without receive-full");
  a_standby_quiet: assert property (@(posedge clock) disable iff (rst)
    standby |=> !rxIrq && !errIrq)
    else $error("request raised in standby");
  a_overrun_keeps: assert property (@(posedge clock) disable iff (rst)
    overrunEv |=> status_one_reg[`FLAG_OVERRUN] && $stable(rx_data_buffer))
    else $error("overrun lost flag or buffer");
  a_mark_wakes: assert property (@(posedge clock) disable iff (rst)
    wakeByMark |=> !standby && status_one_reg[`FLAG_FULL])
    else $error("address mark did not wake");
  a_idle_wake_silent: assert property (@(posedge clock) disable iff (rst)
    (wakeIdle && !status_one_reg[`FLAG_IDLE]) |=> !standby && !status_one_reg[`FLAG_IDLE])
    else $error("idle wakeup misbehaved");
  a_break_protect: assert property (@(posedge clock) disable iff (rst)
    protect |=> (($past(status_one_reg) & ~status_one_reg) == 6'h00))
    else $error("flag cleared while protected");
  a_rx_irq_gate: assert property (@(posedge clock) disable iff (rst)
    rxIrq |-> $past(status_one_reg[`FLAG_FULL] & control_two_reg[`RX_FULL_IRQ_EN]) ||
              $past(status_one_reg[`FLAG_IDLE] & control_two_reg[`LINE_IDLE_IRQ_EN]))
    else $error("receive request without enabled source");
  a_err_irq_or: assert property (@(posedge clock) disable iff (rst)
    (!standby && |(status_one_reg[`FLAG_PARITY:`FLAG_OVERRUN] & control_three_reg)) |=> errIrq)
    else $error("enabled error flag raised no request");
  a_wait_refused: assert property (@(posedge clock) disable iff (rst)
    (arvalid && arready && waitMode) |=> rvalid && rresp == `RESP_SLVERR && rdata == 32'h0)
    else $error("register read in wait mode");
endmodule

//--- tb/rx_line_model.sv
// Purpose: remote transmitter driving the receive pin
// Assumes: bit time of bitClk clocks, same rate as the receiver
// Notes: line idles high between frames
`timescale 1ns/1ps
module rx_line_model #(parameter int bitClk = 16) (
  // link
  input  wire logic clock,
  output logic      line
);
  initial line = 1'b1;
  // exact rate keeps the stop samples inside the stop bit
  task automatic send(input logic [8:0] v, input int n, input logic stopBit);
    for (int i = 0; i < n + 2; i++) begin
      line <= (i == 0) ? 1'b0 : (i <= n) ? v[i-1] : stopBit;
      repeat (bitClk) @(posedge clock);
    end
    // one idle clock keeps back-to-back frames from driving the line twice in a step
    line <= 1'b1;
    @(posedge clock);
  endtask
endmodule

//--- tb/sci_receiver_error_wakeup_tb_top.sv
// Purpose: self-checking bench of the receiver
// Assumes: baud divisor 0, so one bit is 16 clocks
// Notes: idle flag is masked out of most status compares
`timescale 1ns/1ps
`include "rx_cfg.svh"
module sci_receiver_error_wakeup_tb_top;
  logic        clock = 0, rst = 1, rxPin, waitMode = 0, stopMode = 0, breakState = 0, breakClearEn = 0;
  logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, rxIrq, errIrq;
  int          numErrors = 0, samplesChecked = 0, cycles = 0;

  sci_receiver_error_wakeup uut (.clock, .rst, .rxPin, .waitMode, .stopMode, .breakState,
    .breakClearEn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rxIrq, .errIrq);
  rx_line_model #(.bitClk(16)) tx (.clock, .line(rxPin));

  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      numErrors++;
      finish_test;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata; rs = rresp;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic t_frame;
    tx.send(9'h0a5, 8, 1'b1);
    rd(`OFS_STATUS_ONE); chk("status", 32'h01, d & 32'h3d);
    chk("rxIrq", 32'h1, rxIrq);
    rd(`OFS_DATA); chk("data", 32'ha5, d);
    $display("frame test done");
  endtask
  task automatic t_break;
    tx.send(9'h000, 8, 1'b0);
    rd(`OFS_STATUS_ONE); chk("status", 32'h11, d & 32'h3d);
    chk("errIrq", 32'h1, errIrq);
    rd(`OFS_DATA); chk("data", 32'h0, d);
    repeat (2) @(posedge clock);
    chk("errIrq", 32'h0, errIrq);
    $display("break test done");
  endtask
  task automatic t_overrun;
    tx.send(9'h03c, 8, 1'b1);
    tx.send(9'h0c3, 8, 1'b1);
    rd(`OFS_STATUS_ONE); chk("status", 32'h05, d & 32'h3d);
    rd(`OFS_DATA); chk("data", 32'h3c, d);
    $display("overrun test done");
  endtask
  task automatic t_wake;
    wr(`OFS_CONTROL_ONE, 32'h22); wr(`OFS_CONTROL_TWO, 32'h0d); chk("bresp", 32'h0, rs);
    tx.send(9'h012, 8, 1'b1);
    chk("rxIrq", 32'h0, rxIrq);
    tx.send(9'h081, 8, 1'b1);
    rd(`OFS_CONTROL_TWO); chk("ctl2", 32'h09, d);
    rd(`OFS_DATA); chk("data", 32'h81, d);
    $display("wake test done");
  endtask
  task automatic t_wait;
    waitMode <= 1'b1;
    rd(`OFS_DATA); chk("rresp", 32'h2, rs);
    chk("rdata", 32'h0, d);
    wr(`OFS_CONTROL_THREE, 32'h0f); chk("bresp", 32'h2, rs);
    waitMode <= 1'b0;
    rd(`OFS_CONTROL_THREE); chk("ctl3", 32'h104, d);
    $display("wait test done");
  endtask
  task automatic t_brk;
    rd(`OFS_STATUS_ONE); chk("status", 32'h01, d & 32'h3d);
    breakState <= 1'b1;
    rd(`OFS_DATA); rd(`OFS_STATUS_ONE); chk("status", 32'h01, d & 32'h3d);
    breakState <= 1'b0;
    rd(`OFS_DATA); rd(`OFS_STATUS_ONE); chk("status", 32'h00, d & 32'h3d);
    tx.send(9'h055, 8, 1'b1);
    breakState <= 1'b1; breakClearEn <= 1'b1;
    rd(`OFS_STATUS_ONE); rd(`OFS_DATA); chk("data", 32'h55, d);
    breakState <= 1'b0; breakClearEn <= 1'b0;
    rd(`OFS_STATUS_ONE); chk("status", 32'h00, d & 32'h3d);
    repeat (200) @(posedge clock);
    rd(`OFS_STATUS_ONE); chk("idle", 32'h02, d & 32'h02);
    $display("break state test done");
  endtask
  task automatic t_stop;
    stopMode <= 1'b1;
    tx.send(9'h0ff, 8, 1'b1);
    stopMode <= 1'b0;
    rd(`OFS_STATUS_ONE); chk("status", 32'h00, d & 32'h3d);
    rd(`OFS_CONTROL_TWO); chk("ctl2", 32'h09, d);
    $display("stop test done");
  endtask
  task automatic t_idle_wake;
    rd(`OFS_STATUS_ONE); rd(`OFS_DATA);
    wr(`OFS_CONTROL_TWO, 32'h0d); wr(`OFS_CONTROL_ONE, 32'h20);
    rd(`OFS_CONTROL_TWO); chk("ctl2", 32'h09, d);
    rd(`OFS_STATUS_ONE); chk("status", 32'h00, d & 32'h3f);
    $display("idle wake test done");
  endtask
  task automatic t_par;
    wr(`OFS_CONTROL_ONE, 32'h29);
    tx.send(9'h007, 9, 1'b1);
    rd(`OFS_STATUS_ONE); chk("status", 32'h21, d & 32'h3d);
    rd(`OFS_CONTROL_THREE); chk("ctl3", 32'h004, d);
    rd(`OFS_DATA); chk("data", 32'h07, d);
    $display("parity test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    wr(`OFS_BAUD, 32'h0); wr(`OFS_CONTROL_ONE, 32'h20);
    wr(`OFS_CONTROL_TWO, 32'h09); wr(`OFS_CONTROL_THREE, 32'h04);
    t_frame; t_break; t_overrun; t_wake; t_wait; t_brk; t_stop; t_idle_wake; t_par;
    finish_test;
  end
endmodule
